// ### rtl/external_data_space_register_region_decode.sv
`timescale 1ns/1ps
module external_data_space_register_region_decode
  import regmap_pkg::*;
#(
  parameter int FREQ_COUNT_W = 32,
  parameter int OTP_BYTES    = XR_OTP_BYTES
) (
  input  wire logic                   CLK,
  input  wire logic                   RESET,
  input  wire sfr_req_s               SFR_REQ,
  output logic [7:0]                  SFR_RDATA,
  output logic                        SFR_HIT,
  input  wire extended_register_region_req_s              EXTENDED_REGISTER_REGION_REQ,
  output logic [7:0]                  EXTENDED_REGISTER_REGION_RDATA,
  output logic                        EXTENDED_REGISTER_REGION_HIT,
  input  wire logic [FREQ_COUNT_W-1:0] FREQ_COUNT_IN,
  input  wire logic [OTP_BYTES*8-1:0] OTP_DATA_IN,
  output logic [SFR_COUNT*8-1:0]      SFR_VALUES,
  output logic [7:0]                  SLOW_OSC_TRIM,
  output logic [AMP_CAP_FIELD_W-1:0]  AMP_TUNING_CAP,
  output logic [7:0]                  AMP_MAX_DRIVE,
  output logic [7:0]                  XTAL_OSC_CTRL,
  output logic [7:0]                  PIN_TEST
);

  // Wider counts would not fit the four-byte slot
  initial begin
    if (FREQ_COUNT_W < 1 || FREQ_COUNT_W > 32) begin
      $error("FREQ_COUNT_W out of range");
    end
  end

  // The array window is sixteen bytes; more would run into other space
  initial begin
    if (OTP_BYTES < 1 || OTP_BYTES > 16) begin
      $error("OTP_BYTES out of range");
    end
  end

  // The capacitor field must need its upper byte and still fit the word
  initial begin
    if (AMP_CAP_FIELD_W <= 8 || AMP_CAP_FIELD_W > 16) begin
      $error("AMP_CAP_FIELD_W does not fit a word");
    end
  end

  // Slot decodes below use low address bits, so the bases must be aligned
  initial begin
    if (XR_FREQ_COUNT[1:0] != 2'h0) begin
      $error("count slot not on a four-byte boundary");
    end
    if (XR_AMP_TUNING_CAP[0] != 1'b0) begin
      $error("capacitor word not on a two-byte boundary");
    end
    if (XR_OTP_READ_BASE[3:0] != 4'h0) begin
      $error("array base not on a sixteen-byte boundary");
    end
  end

  localparam logic [7:0] SFR_ADDRS [SFR_COUNT] = '{
    SFR_STACK_POINTER, SFR_CIPHER_SUBST, SFR_TIMER_B_CONTROL, SFR_TIMER_B_RELOAD_LO,
    SFR_TIMER_B_RELOAD_HI, SFR_TIMER_B_COUNT_LO, SFR_TIMER_B_COUNT_HI, SFR_BIT_READ_DATA,
    SFR_CLOCK_TICK_CTRL, SFR_PIN_SET, SFR_PIN_INT_CONFIG, SFR_SYSTEM_GENERATOR,
    SFR_TIMER_A_CONTROL, SFR_TIMER_SRC_SELECT, SFR_TIMER_A_RELOAD_LO, SFR_TIMER_A_RELOAD_HI,
    SFR_TIMER_A_COUNT_LO, SFR_TIMER_A_COUNT_HI, SFR_STATUS_WORD, SFR_PROTECTION_CTRL,
    SFR_SYSTEM_SETUP};

  // Every listed register sits in the direct space and no two collide
  initial begin
    for (int i = 0; i < SFR_COUNT; i++) begin
      if (SFR_ADDRS[i] < SFR_BASE) begin
        $error("special register below the direct space");
      end
      for (int j = i + 1; j < SFR_COUNT; j++) begin
        if (SFR_ADDRS[i] == SFR_ADDRS[j]) begin
          $error("two special registers share an address");
        end
      end
    end
  end

  logic [7:0]                 sfr_q [SFR_COUNT];
  logic [SFR_COUNT-1:0]       sfr_sel;
  logic                       sfr_bit_ok;
  logic [7:0]                 sfr_rd_d;
  logic                       sfr_hit_d;
  logic [7:0]                 slow_osc_trim_q;
  logic [AMP_CAP_FIELD_W-1:0] amp_cap_q;
  logic [7:0]                 amp_max_drive_q;
  logic [7:0]                 xtal_osc_ctrl_q;
  logic [7:0]                 pin_test_q;
  logic [31:0]                freq_slot;
  logic [15:0]                amp_cap_word;
  logic [15:0]                otp_offset;
  logic [7:0]                 extended_register_region_rd_d;
  logic                       extended_register_region_hit_d;

  // Direct-address decode, one select per assigned location
  always_comb begin
    for (int i = 0; i < SFR_COUNT; i++) begin
      sfr_sel[i] = SFR_REQ.valid && (SFR_REQ.addr == SFR_ADDRS[i]);
    end
  end

  // Bit accesses only reach registers in the 0x0 / 0x8 columns
  assign sfr_bit_ok = (SFR_REQ.addr[2:0] == SFR_BIT_ADDR_NIBBLE);

  // Special register storage; a refused bit op leaves the byte untouched
  always_ff @(posedge CLK) begin
    if (RESET) begin
      for (int i = 0; i < SFR_COUNT; i++) begin
        sfr_q[i] <= RESET_BYTE;
      end
    end else if (SFR_REQ.valid && SFR_REQ.write) begin
      for (int i = 0; i < SFR_COUNT; i++) begin
        if (sfr_sel[i] && !SFR_REQ.bit_op) begin
          sfr_q[i] <= SFR_REQ.wdata;
        end else if (sfr_sel[i] && sfr_bit_ok) begin
          sfr_q[i][SFR_REQ.bit_sel] <= SFR_REQ.wdata[0];
        end
      end
    end
  end

  logic [7:0] sfr_byte;
  // Byte of the addressed register; reserved locations give zero
  always_comb begin
    sfr_byte = 8'h00;
    for (int i = 0; i < SFR_COUNT; i++) begin
      if (sfr_sel[i]) begin
        sfr_byte = sfr_q[i];
      end
    end
  end

  // A bit access returns its bit in bit 0; an off-column one is refused
  always_comb begin
    sfr_hit_d = (|sfr_sel) && (!SFR_REQ.bit_op || sfr_bit_ok);
    if (!sfr_hit_d) begin
      sfr_rd_d = 8'h00;
    end else if (SFR_REQ.bit_op) begin
      sfr_rd_d = {7'h00, sfr_byte[SFR_REQ.bit_sel]};
    end else begin
      sfr_rd_d = sfr_byte;
    end
  end

  // Registered read byte, one cycle after the access
  always_ff @(posedge CLK) begin
    if (RESET) begin
      SFR_RDATA <= 8'h00;
    end else begin
      SFR_RDATA <= sfr_rd_d;
    end
  end

  // Hit flag alongside it; reserved or refused accesses leave it low
  always_ff @(posedge CLK) begin
    if (RESET) begin
      SFR_HIT <= 1'b0;
    end else begin
      SFR_HIT <= sfr_hit_d;
    end
  end

  // Flatten special registers for the peripherals behind them
  always_comb begin
    for (int i = 0; i < SFR_COUNT; i++) begin
      SFR_VALUES[i*8 +: 8] = sfr_q[i];
    end
  end

  // Big-endian slots: counter zero-extended to 32 bits, LSB at base+3
  assign freq_slot    = 32'(FREQ_COUNT_IN);
  assign amp_cap_word = {{(16-AMP_CAP_FIELD_W){1'b0}}, amp_cap_q};
  assign otp_offset   = EXTENDED_REGISTER_REGION_REQ.addr - XR_OTP_READ_BASE;

  // Extended region strobes, decodes and capacitor halves
  logic                       xr_wr;
  logic                       hit_trim;
  logic                       hit_count;
  logic                       hit_cap_hi;
  logic                       hit_cap_lo;
  logic                       hit_drive;
  logic                       hit_xtal;
  logic                       hit_pin_test;
  logic                       hit_otp;
  logic                       hit_any;
  logic [7:0]                 amp_cap_lo_q;
  logic [AMP_CAP_FIELD_W-9:0] amp_cap_hi_q;
  logic [AMP_CAP_FIELD_W-9:0] cap_hi_wdata;

  // Field in two halves: the upper byte carries only the bits above 7
  assign amp_cap_q = {amp_cap_hi_q, amp_cap_lo_q};

  // Moves only; the direct-address path never reaches this region
  assign xr_wr = EXTENDED_REGISTER_REGION_REQ.valid && EXTENDED_REGISTER_REGION_REQ.write;

  // Byte decode of each mapped location
  assign hit_trim     = (EXTENDED_REGISTER_REGION_REQ.addr == XR_SLOW_OSC_TRIM);
  assign hit_count    = (EXTENDED_REGISTER_REGION_REQ.addr[15:2] == XR_FREQ_COUNT[15:2]);
  assign hit_cap_hi   = (EXTENDED_REGISTER_REGION_REQ.addr == XR_AMP_TUNING_CAP);
  assign hit_cap_lo   = (EXTENDED_REGISTER_REGION_REQ.addr == XR_AMP_TUNING_CAP + 16'h0001);
  assign hit_drive    = (EXTENDED_REGISTER_REGION_REQ.addr == XR_AMP_MAX_DRIVE);
  assign hit_xtal     = (EXTENDED_REGISTER_REGION_REQ.addr == XR_XTAL_OSC_CTRL);
  assign hit_pin_test = (EXTENDED_REGISTER_REGION_REQ.addr == XR_PIN_TEST);
  // Offset test alone would wrap for addresses under the base
  assign hit_otp      = (EXTENDED_REGISTER_REGION_REQ.addr >= XR_OTP_READ_BASE) &&
                        (otp_offset < 16'(OTP_BYTES));
  assign hit_any      = hit_trim | hit_count | hit_cap_hi | hit_cap_lo |
                        hit_drive | hit_xtal | hit_pin_test |
                        hit_otp;

  // Array bytes by per-element select, element zero at the base
  logic [OTP_BYTES-1:0] otp_sel;
  logic [7:0]           otp_byte;
  for (genvar k = 0; k < OTP_BYTES; k++) begin : g_otp_sel
    assign otp_sel[k] = hit_otp && (otp_offset[3:0] == 4'(k));
  end
  always_comb begin
    otp_byte = 8'h00;
    for (int k = 0; k < OTP_BYTES; k++) begin
      if (otp_sel[k]) begin
        otp_byte = OTP_DATA_IN[8*k +: 8];
      end
    end
  end

  // Slow oscillator trim, a full byte
  always_ff @(posedge CLK) begin
    if (RESET) begin
      slow_osc_trim_q <= RESET_BYTE;
    end else if (xr_wr && hit_trim) begin
      slow_osc_trim_q <= EXTENDED_REGISTER_REGION_REQ.wdata;
    end
  end

  // Amplifier maximum drive
  always_ff @(posedge CLK) begin
    if (RESET) begin
      amp_max_drive_q <= RESET_BYTE;
    end else if (xr_wr && hit_drive) begin
      amp_max_drive_q <= EXTENDED_REGISTER_REGION_REQ.wdata;
    end
  end

  // Crystal oscillator control
  always_ff @(posedge CLK) begin
    if (RESET) begin
      xtal_osc_ctrl_q <= RESET_BYTE;
    end else if (xr_wr && hit_xtal) begin
      xtal_osc_ctrl_q <= EXTENDED_REGISTER_REGION_REQ.wdata;
    end
  end

  // Pin test byte; gaps and read-only bytes have no store at all
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pin_test_q <= RESET_BYTE;
    end else if (xr_wr && hit_pin_test) begin
      pin_test_q <= EXTENDED_REGISTER_REGION_REQ.wdata;
    end
  end

  // Capacitor low byte sits at the higher address
  always_ff @(posedge CLK) begin
    if (RESET) begin
      amp_cap_lo_q <= RESET_BYTE;
    end else if (xr_wr && hit_cap_lo) begin
      amp_cap_lo_q <= EXTENDED_REGISTER_REGION_REQ.wdata;
    end
  end

  // Bits 15:9 have no storage, so their part of a write is simply lost
  assign cap_hi_wdata = EXTENDED_REGISTER_REGION_REQ.wdata[AMP_CAP_FIELD_W-9:0];

  // Upper field bits, in the low end of the lower-addressed byte
  always_ff @(posedge CLK) begin
    if (RESET) begin
      amp_cap_hi_q <= '0;
    end else if (xr_wr && hit_cap_hi) begin
      amp_cap_hi_q <= cap_hi_wdata;
    end
  end

  // Read mux; idle cycles and misses read zero with no hit
  always_comb begin
    extended_register_region_rd_d  = 8'h00;
    extended_register_region_hit_d = EXTENDED_REGISTER_REGION_REQ.valid && hit_any;
    if (!EXTENDED_REGISTER_REGION_REQ.valid) begin
      extended_register_region_rd_d = 8'h00;
    end else if (hit_trim) begin
      extended_register_region_rd_d = slow_osc_trim_q;
    end else if (hit_count) begin
      case (EXTENDED_REGISTER_REGION_REQ.addr[1:0])
        2'h0:    extended_register_region_rd_d = freq_slot[31:24];
        2'h1:    extended_register_region_rd_d = freq_slot[23:16];
        2'h2:    extended_register_region_rd_d = freq_slot[15:8];
        default: extended_register_region_rd_d = freq_slot[7:0];
      endcase
    end else if (hit_cap_hi) begin
      extended_register_region_rd_d = amp_cap_word[15:8];
    end else if (hit_cap_lo) begin
      extended_register_region_rd_d = amp_cap_word[7:0];
    end else if (hit_drive) begin
      extended_register_region_rd_d = amp_max_drive_q;
    end else if (hit_xtal) begin
      extended_register_region_rd_d = xtal_osc_ctrl_q;
    end else if (hit_pin_test) begin
      extended_register_region_rd_d = pin_test_q;
    end else if (hit_otp) begin
      extended_register_region_rd_d = otp_byte;
    end
  end

  // Registered read byte, one cycle after the move is presented
  always_ff @(posedge CLK) begin
    if (RESET) begin
      EXTENDED_REGISTER_REGION_RDATA <= 8'h00;
    end else begin
      EXTENDED_REGISTER_REGION_RDATA <= extended_register_region_rd_d;
    end
  end

  // Hit flag alongside it; gaps and idle cycles leave it low
  always_ff @(posedge CLK) begin
    if (RESET) begin
      EXTENDED_REGISTER_REGION_HIT <= 1'b0;
    end else begin
      EXTENDED_REGISTER_REGION_HIT <= extended_register_region_hit_d;
    end
  end

  assign SLOW_OSC_TRIM  = slow_osc_trim_q;
  assign AMP_TUNING_CAP = amp_cap_q;
  assign AMP_MAX_DRIVE  = amp_max_drive_q;
  assign XTAL_OSC_CTRL  = xtal_osc_ctrl_q;
  assign PIN_TEST       = pin_test_q;

endmodule : external_data_space_register_region_decode

// ### shared/regmap_pkg.sv
package regmap_pkg;

  // Direct-address special-function register decode
  localparam logic [7:0] SFR_BASE              = 8'h80;
  localparam logic [7:0] SFR_STACK_POINTER     = 8'h81;
  localparam logic [7:0] SFR_CIPHER_SUBST      = 8'h86;
  localparam logic [7:0] SFR_TIMER_B_CONTROL   = 8'h91;
  localparam logic [7:0] SFR_TIMER_B_RELOAD_LO = 8'h92;
  localparam logic [7:0] SFR_TIMER_B_RELOAD_HI = 8'h93;
  localparam logic [7:0] SFR_TIMER_B_COUNT_LO  = 8'h94;
  localparam logic [7:0] SFR_TIMER_B_COUNT_HI  = 8'h95;
  localparam logic [7:0] SFR_BIT_READ_DATA     = 8'h99;
  localparam logic [7:0] SFR_CLOCK_TICK_CTRL   = 8'h9C;
  localparam logic [7:0] SFR_PIN_SET           = 8'hB6;
  localparam logic [7:0] SFR_PIN_INT_CONFIG    = 8'hB7;
  localparam logic [7:0] SFR_SYSTEM_GENERATOR  = 8'hBE;
  localparam logic [7:0] SFR_TIMER_A_CONTROL   = 8'hC8;
  localparam logic [7:0] SFR_TIMER_SRC_SELECT  = 8'hC9;
  localparam logic [7:0] SFR_TIMER_A_RELOAD_LO = 8'hCA;
  localparam logic [7:0] SFR_TIMER_A_RELOAD_HI = 8'hCB;
  localparam logic [7:0] SFR_TIMER_A_COUNT_LO  = 8'hCC;
  localparam logic [7:0] SFR_TIMER_A_COUNT_HI  = 8'hCD;
  localparam logic [7:0] SFR_STATUS_WORD       = 8'hD0;
  localparam logic [7:0] SFR_PROTECTION_CTRL   = 8'hDA;
  localparam logic [7:0] SFR_SYSTEM_SETUP      = 8'hEE;
  localparam int         SFR_COUNT             = 21;
  localparam logic [2:0] SFR_BIT_ADDR_NIBBLE   = 3'h0; // low 3 bits of 0x0 / 0x8 rows

  // Extended register region in external data space
  localparam logic [15:0] XR_SLOW_OSC_TRIM   = 16'h4002;
  localparam logic [15:0] XR_FREQ_COUNT      = 16'h4008; // 4-byte slot
  localparam logic [15:0] XR_AMP_TUNING_CAP  = 16'h400C; // 2-byte word
  localparam logic [15:0] XR_AMP_MAX_DRIVE   = 16'h4012;
  localparam logic [15:0] XR_XTAL_OSC_CTRL   = 16'h4016;
  localparam logic [15:0] XR_PIN_TEST        = 16'h4017;
  localparam logic [15:0] XR_OTP_READ_BASE   = 16'h4040;
  localparam int          XR_OTP_BYTES       = 16;
  localparam int          AMP_CAP_FIELD_W    = 9;
  localparam logic [7:0]  RESET_BYTE         = 8'h00;

  // Processor access request as seen by the decoder
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        bit_op;   // single-bit access
    logic [2:0]  bit_sel;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } sfr_req_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } extended_register_region_req_s;

endpackage : regmap_pkg

// ### verif/external_data_space_register_region_decode_assertions.sv
`timescale 1ns/1ps
module external_data_space_register_region_decode_assertions
  import regmap_pkg::*;
#(
  parameter int FREQ_COUNT_W = 32,
  parameter int OTP_BYTES    = XR_OTP_BYTES
) (
  input wire logic                       CLK,
  input wire logic                       RESET,
  input wire sfr_req_s                   SFR_REQ,
  input wire logic [7:0]                 SFR_RDATA,
  input wire logic                       SFR_HIT,
  input wire extended_register_region_req_s                  EXTENDED_REGISTER_REGION_REQ,
  input wire logic [7:0]                 EXTENDED_REGISTER_REGION_RDATA,
  input wire logic                       EXTENDED_REGISTER_REGION_HIT,
  input wire logic [FREQ_COUNT_W-1:0]    FREQ_COUNT_IN,
  input wire logic [OTP_BYTES*8-1:0]     OTP_DATA_IN,
  input wire logic [SFR_COUNT*8-1:0]     SFR_VALUES,
  input wire logic [AMP_CAP_FIELD_W-1:0] AMP_TUNING_CAP
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  wire  [31:0] cnt32 = 32'(FREQ_COUNT_IN);
  logic [7:0]  exp_q, wd_q, sw_q;
  // Live source bytes bypass storage, so predict them one cycle ahead
  always_ff @(posedge CLK) begin
    exp_q <= EXTENDED_REGISTER_REGION_REQ.addr[6] ? OTP_DATA_IN[8*EXTENDED_REGISTER_REGION_REQ.addr[3:0] +: 8]
                              : cnt32[8*(3-EXTENDED_REGISTER_REGION_REQ.addr[1:0]) +: 8];
    wd_q  <= EXTENDED_REGISTER_REGION_REQ.wdata;
    sw_q  <= SFR_REQ.wdata;
  end
  sequence s_cnt_rd;
    EXTENDED_REGISTER_REGION_REQ.valid && !EXTENDED_REGISTER_REGION_REQ.write && EXTENDED_REGISTER_REGION_REQ.addr[15:2] == XR_FREQ_COUNT[15:2];
  endsequence
  sequence s_otp_rd;
    EXTENDED_REGISTER_REGION_REQ.valid && !EXTENDED_REGISTER_REGION_REQ.write && EXTENDED_REGISTER_REGION_REQ.addr[15:4] == XR_OTP_READ_BASE[15:4];
  endsequence
  sequence s_cap_wr;
    EXTENDED_REGISTER_REGION_REQ.valid && EXTENDED_REGISTER_REGION_REQ.write && EXTENDED_REGISTER_REGION_REQ.addr == XR_AMP_TUNING_CAP + 16'h1;
  endsequence
  a_sfr_idle_quiet: assert property (!SFR_REQ.valid |=> SFR_RDATA == 8'h00 && !SFR_HIT)
    else $error("sfr answer without request");
  a_xr_idle_quiet: assert property (!EXTENDED_REGISTER_REGION_REQ.valid |=> EXTENDED_REGISTER_REGION_RDATA == 8'h00 && !EXTENDED_REGISTER_REGION_HIT)
    else $error("extended answer without request");
  a_bit_misalign: assert property (SFR_REQ.valid && SFR_REQ.bit_op && SFR_REQ.addr[2:0] != 3'h0
    |=> !SFR_HIT && SFR_RDATA == 8'h00) else $error("bit access accepted off row");
  a_status_write: assert property (SFR_REQ.valid && SFR_REQ.write && !SFR_REQ.bit_op
    && SFR_REQ.addr == SFR_STATUS_WORD |=> SFR_HIT && SFR_VALUES[151:144] == sw_q)
    else $error("status word write lost");
  a_count_order: assert property (s_cnt_rd |=> EXTENDED_REGISTER_REGION_HIT && EXTENDED_REGISTER_REGION_RDATA == exp_q)
    else $error("count byte order wrong");
  a_array_order: assert property (s_otp_rd |=> EXTENDED_REGISTER_REGION_HIT && EXTENDED_REGISTER_REGION_RDATA == exp_q)
    else $error("array byte order wrong");
  a_cap_upper_zero: assert property (EXTENDED_REGISTER_REGION_REQ.valid && EXTENDED_REGISTER_REGION_REQ.addr == XR_AMP_TUNING_CAP
    |=> EXTENDED_REGISTER_REGION_RDATA[7:1] == 7'h00) else $error("capacitor upper bits not zero");
  a_cap_low_write: assert property (s_cap_wr |=> EXTENDED_REGISTER_REGION_HIT && AMP_TUNING_CAP[7:0] == wd_q)
    else $error("capacitor low byte write lost");
  a_xr_gap_zero: assert property (EXTENDED_REGISTER_REGION_REQ.valid && EXTENDED_REGISTER_REGION_REQ.addr inside
    {[16'h4003:16'h4007], [16'h400E:16'h4011]} |=> EXTENDED_REGISTER_REGION_RDATA == 8'h00 && !EXTENDED_REGISTER_REGION_HIT)
    else $error("gap address answered");
endmodule : external_data_space_register_region_decode_assertions

bind external_data_space_register_region_decode external_data_space_register_region_decode_assertions #(
  .FREQ_COUNT_W(FREQ_COUNT_W), .OTP_BYTES(OTP_BYTES)) i_chk (
  .CLK(CLK), .RESET(RESET), .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT),
  .EXTENDED_REGISTER_REGION_REQ(EXTENDED_REGISTER_REGION_REQ), .EXTENDED_REGISTER_REGION_RDATA(EXTENDED_REGISTER_REGION_RDATA), .EXTENDED_REGISTER_REGION_HIT(EXTENDED_REGISTER_REGION_HIT),
  .FREQ_COUNT_IN(FREQ_COUNT_IN), .OTP_DATA_IN(OTP_DATA_IN), .SFR_VALUES(SFR_VALUES),
  .AMP_TUNING_CAP(AMP_TUNING_CAP));

// ### verif/core_model.sv
`timescale 1ns/1ps
module core_model
  import regmap_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] sfr_rdata,
  input  wire logic       sfr_hit,
  input  wire logic [7:0] extended_register_region_rdata,
  input  wire logic       extended_register_region_hit,
  output sfr_req_s        sfr_req = '0,
  output extended_register_region_req_s       extended_register_region_req = '0
);
  // Direct access: one cycle request, answer after the taking edge
  task automatic special_function_register(input logic w, b, input logic [2:0] s, input logic [7:0] a, d,
                     output logic [8:0] r);
    @(posedge clk);
    sfr_req <= '{1'b1, w, b, s, a, d};
    @(posedge clk);
    sfr_req <= '{1'b0, 1'b0, 1'b0, ~s, ~a, ~d}; // Released lines scrambled
    #1 r = {sfr_hit, sfr_rdata};
  endtask : special_function_register
  // External-memory move, one byte per access
  task automatic xr(input logic w, input logic [15:0] a, input logic [7:0] d,
                    output logic [8:0] r);
    @(posedge clk);
    extended_register_region_req <= '{1'b1, w, a, d};
    @(posedge clk);
    extended_register_region_req <= '{1'b0, 1'b0, ~a, ~d};
    #1 r = {extended_register_region_hit, extended_register_region_rdata};
  endtask : xr
endmodule : core_model

// ### verif/external_data_space_register_region_decode_test.sv
`timescale 1ns/1ps
module external_data_space_register_region_decode_test
  import regmap_pkg::*;
;
  logic                   clk = 1'b0;
  logic                   reset = 1'b1;
  sfr_req_s               sfr_req;
  extended_register_region_req_s              extended_register_region_req;
  logic [7:0]             sfr_rdata, extended_register_region_rdata, pin_test;
  logic [7:0]             slow_trim, max_drive, xtal_ctrl;
  logic                   sfr_hit, extended_register_region_hit;
  logic [22:0]            freq_cnt = 23'h345678; // Narrow count: empty top byte
  logic [127:0]           otp;
  logic [SFR_COUNT*8-1:0] sfr_values;
  logic [8:0]             amp_cap, r;
  int                     error_cnt = 0;
  int                     samples_checked = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  core_model i_core_model (.clk(clk), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .extended_register_region_rdata(extended_register_region_rdata), .extended_register_region_hit(extended_register_region_hit), .sfr_req(sfr_req), .extended_register_region_req(extended_register_region_req));
  external_data_space_register_region_decode #(.FREQ_COUNT_W(23)) i_external_data_space_register_region_decode (
    .CLK(clk), .RESET(reset), .SFR_REQ(sfr_req), .SFR_RDATA(sfr_rdata), .SFR_HIT(sfr_hit),
    .EXTENDED_REGISTER_REGION_REQ(extended_register_region_req), .EXTENDED_REGISTER_REGION_RDATA(extended_register_region_rdata), .EXTENDED_REGISTER_REGION_HIT(extended_register_region_hit),
    .FREQ_COUNT_IN(freq_cnt), .OTP_DATA_IN(otp), .SFR_VALUES(sfr_values),
    .SLOW_OSC_TRIM(slow_trim), .AMP_TUNING_CAP(amp_cap), .AMP_MAX_DRIVE(max_drive),
    .XTAL_OSC_CTRL(xtal_ctrl),
    .PIN_TEST(pin_test));
  task automatic chk(input string what, input logic [8:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  // Byte and bit access on direct registers, off-row bit refused
  task automatic t_sfr;
    i_core_model.special_function_register(1, 0, 0, SFR_STATUS_WORD, 8'hA5, r);
    i_core_model.special_function_register(0, 0, 0, SFR_STATUS_WORD, 8'h00, r);
    chk("status read", r, 9'h1A5);
    chk("status value", {1'b0, sfr_values[151:144]}, 9'h0A5);
    i_core_model.special_function_register(1, 0, 0, SFR_TIMER_A_CONTROL, 8'h08, r);
    i_core_model.special_function_register(0, 1, 3, SFR_TIMER_A_CONTROL, 8'h00, r);
    chk("bit read", r, 9'h101);
    i_core_model.special_function_register(1, 1, 0, SFR_TIMER_A_CONTROL, 8'h01, r);
    i_core_model.special_function_register(0, 0, 0, SFR_TIMER_A_CONTROL, 8'h00, r);
    chk("bit write", r, 9'h109);
    i_core_model.special_function_register(1, 0, 0, SFR_STACK_POINTER, 8'h3C, r);
    i_core_model.special_function_register(1, 1, 0, SFR_STACK_POINTER, 8'h01, r);
    chk("off-row bit", r, 9'h000);
    i_core_model.special_function_register(0, 0, 0, SFR_STACK_POINTER, 8'h00, r);
    chk("stack read", r, 9'h13C);
    i_core_model.special_function_register(0, 0, 0, 8'h8A, 8'h00, r);
    chk("reserved sfr", r, 9'h000);
    $display("direct register test done");
  endtask : t_sfr
  // Extended region: order, empty bytes, read-only, gaps, array
  task automatic t_extended_register_region;
    i_core_model.xr(1, XR_FREQ_COUNT, 8'hFF, r);
    for (int i = 0; i < 4; i++) begin
      i_core_model.xr(0, XR_FREQ_COUNT + 16'(i), 8'h00, r);
      chk("count byte", r, {1'b1, i == 0 ? 8'h00 : 8'(8'h12 + 8'h22 * i)});
    end
    i_core_model.xr(1, XR_AMP_TUNING_CAP, 8'hFF, r);
    i_core_model.xr(1, XR_AMP_TUNING_CAP + 16'h1, 8'h5A, r);
    i_core_model.xr(0, XR_AMP_TUNING_CAP, 8'h00, r);
    chk("cap high byte", r, 9'h101);
    chk("cap field", amp_cap, 9'h15A);
    i_core_model.xr(1, 16'h4005, 8'hFF, r);
    i_core_model.xr(0, 16'h4005, 8'h00, r);
    chk("gap byte", r, 9'h000);
    i_core_model.xr(1, XR_PIN_TEST, 8'hC3, r);
    i_core_model.xr(0, XR_PIN_TEST, 8'h00, r);
    chk("pin test", r, 9'h1C3);
    chk("pin test out", {1'b0, pin_test}, 9'h0C3);
    i_core_model.xr(1, XR_SLOW_OSC_TRIM, 8'h11, r);
    i_core_model.xr(1, XR_AMP_MAX_DRIVE, 8'h22, r);
    i_core_model.xr(1, XR_XTAL_OSC_CTRL, 8'h33, r);
    i_core_model.xr(0, XR_SLOW_OSC_TRIM, 8'h00, r);
    chk("trim read", r, 9'h111);
    chk("trim out", {1'b0, slow_trim}, 9'h011);
    chk("drive out", {1'b0, max_drive}, 9'h022);
    chk("xtal out", {1'b0, xtal_ctrl}, 9'h033);
    foreach (otp[i]) if (i % 120 == 0) begin
      i_core_model.xr(0, XR_OTP_READ_BASE + 16'(i / 8), 8'h00, r);
      chk("array byte", r, {1'b1, 8'(8'h40 + i / 8)});
    end
    $display("extended region test done");
  endtask : t_extended_register_region
  // Array byte k holds 0x40+k
  initial begin
    for (int k = 0; k < 16; k++) otp[8*k +: 8] = 8'(8'h40 + k);
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_sfr();
    t_extended_register_region();
    test_done();
  end
  // Watchdog well beyond the seventy or so cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule : external_data_space_register_region_decode_test
